// *** rtl/ors_core.sv ***
// Overview of operation
// - queries arrive without parameters, just instruction
// - comma between consecutive response items
// - bus: send only when addressed to talk
// - bus: new query replaces pending response
// - bus: response ends with CR then LF
// - bus: EOI asserted with the closing LF
// - serial: send at once, obey delays
// - serial: query while busy gives error 10
// - serial: terminator one CR, configurable
// - mask instruction: three params 0 to 255
// - init sets masks 223, 0, 0
// - empty mask instruction loads the defaults
// - bus: service request from masked status
// - bus: parallel poll one on masked status
// - serial: service and poll masks ignored
// - enabled error sets status bit 5, display
// - error n maps to mask bit n-1
// - masked error leaves no visible trace
// - mask instruction produces no response
// - status change ANDed with mask sets bit 6; code sets it on any status change while status AND mask is nonzero
// - over three params error 2; range error 3
//
// Local design decisions: the register addresses and the APB interface to the registers.
`include "ors_defines.svh"
module ors_core (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // apb slave
   input  wire logic [11:0]           paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output      logic [31:0]           prdata,
   output      logic                  pready,
   output      logic                  pslverr,
   // parsed instructions
   input  wire logic                  q_valid,
   input  wire ors_pkg::ors_resp_t    q_resp,
   input  wire logic                  m_valid,
   input  wire ors_pkg::ors_mask_cmd_t m_cmd,
   input  wire logic                  err_valid,
   input  wire logic [3:0]            err_in,
   input  wire logic                  err_clear,
   input  wire logic                  init_req,
   // status and bus front end
   input  wire logic [4:0]            stat_in,
   input  wire logic                  talk_rd,
   input  wire logic                  spoll_done,
   output      logic                  srq,
   output      logic                  ppoll_resp,
   // response byte stream
   output      logic                  tx_valid,
   input  wire logic                  tx_ready,
   output      logic [7:0]            tx_data,
   output      logic                  tx_eoi,
   // front panel
   output      logic                  err_show,
   output      logic [3:0]            err_num
);
   localparam logic [7:0] TICK_LAST = 8'(`ORS_TICK_CYC - 1);

   ors_pkg::ors_state_t s_ff;
   ors_pkg::ors_state_t nxt_s;

   function automatic logic [7:0] byte_of(input ors_pkg::ors_state_t x);
      logic [7:0] b;
      b = `ORS_LF;
      unique case (x.seg)
         ors_pkg::SG_ITEM:  b = x.rbuf.chr[x.item][x.chr];
         ors_pkg::SG_COMMA: b = `ORS_COMMA;
         ors_pkg::SG_CR:    b = x.cfg.serial ? x.cfg.term : `ORS_CR;
         ors_pkg::SG_LF:    b = `ORS_LF;
      endcase
      return b;
   endfunction

   logic [7:0] sbyte;
   logic [5:0] low6;
   logic       can_talk;
   logic       fire;
   logic [3:0] nuse;
   logic       mbad;

   assign low6     = {s_ff.sb_err, stat_in};
   assign sbyte    = {1'b0, s_ff.sb_rqs, low6};
   assign can_talk = s_ff.cfg.serial | (talk_rd & ~s_ff.cfg.lonly);
   assign tx_valid = (s_ff.st == ors_pkg::ST_SEND) & s_ff.pend & can_talk;
   assign fire     = tx_valid & tx_ready;
   assign tx_data  = s_ff.txb;
   assign tx_eoi   = tx_valid & ~s_ff.cfg.serial & (s_ff.seg == ors_pkg::SG_LF);
   assign srq      = s_ff.sb_rqs & ~s_ff.cfg.serial;
   assign ppoll_resp = ~s_ff.cfg.serial & (|(sbyte & s_ff.pmask));
   assign err_show = s_ff.err_show;
   assign err_num  = s_ff.err_num;
   assign prdata   = s_ff.prdata;
   assign pslverr  = s_ff.pslverr;
   assign pready   = 1'b1;
   assign nuse     = (m_cmd.cnt > `ORS_MAXP) ? `ORS_MAXP : m_cmd.cnt;

   always_comb begin
      mbad = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (4'(i) < nuse && m_cmd.par[i] > `ORS_MAXV) begin
            mbad = 1'b1;
         end
      end
   end

   always_comb begin
      logic       ev;
      logic [3:0] code;
      ev = 1'b0;
      code = 4'h0;
      nxt_s = s_ff;

      // read data latched in setup so the access phase needs no wait
      if (psel && !penable) begin
         nxt_s.prdata = 32'h0000_0000;
         nxt_s.pslverr = 1'b0;
         case (paddr)
            `ORS_A_CTRL: nxt_s.prdata = {30'h0, s_ff.cfg.lonly, s_ff.cfg.serial};
            `ORS_A_SCFG: nxt_s.prdata = {8'h00, s_ff.cfg.cdly, s_ff.cfg.tdly, s_ff.cfg.term};
            `ORS_A_MASK: nxt_s.prdata = {8'h00, s_ff.pmask, s_ff.smask, s_ff.emask};
            `ORS_A_STAT: nxt_s.prdata = {18'h0, s_ff.st == ors_pkg::ST_SEND, s_ff.pend,
                                         s_ff.err_num, sbyte};
            default:     nxt_s.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && pwrite) begin
         case (paddr)
            `ORS_A_CTRL: begin
               nxt_s.cfg.serial = pwdata[0];
               nxt_s.cfg.lonly = pwdata[1];
            end
            `ORS_A_SCFG: begin
               nxt_s.cfg.term = pwdata[7:0];
               nxt_s.cfg.tdly = pwdata[15:8];
               nxt_s.cfg.cdly = pwdata[23:16];
            end
            default: ;
         endcase
      end

      // 1 us tick for the serial delays
      if (s_ff.tick == TICK_LAST) begin
         nxt_s.tick = 8'h00;
      end else begin
         nxt_s.tick = s_ff.tick + 8'h01;
      end

      if (err_valid) begin
         ev = 1'b1;
         code = err_in;
      end

      // mask instruction never touches the response path
      if (m_valid) begin
         if (m_cmd.cnt == 4'h0) begin
            nxt_s.emask = `ORS_EMASK_DEF;
            nxt_s.smask = `ORS_SMASK_DEF;
            nxt_s.pmask = `ORS_PMASK_DEF;
         end else if (mbad) begin
            ev = 1'b1;
            code = `ORS_ERR_PRNG;
         end else begin
            nxt_s.emask = m_cmd.par[0][7:0];
            if (nuse > 4'h1 && !s_ff.cfg.serial) begin
               nxt_s.smask = m_cmd.par[1][7:0];
            end
            if (nuse > 4'h2 && !s_ff.cfg.serial) begin
               nxt_s.pmask = m_cmd.par[2][7:0];
            end
            if (m_cmd.cnt > `ORS_MAXP) begin
               ev = 1'b1;
               code = `ORS_ERR_PCNT;
            end
         end
      end

      // response serialiser
      unique case (s_ff.st)
         ors_pkg::ST_IDLE: ;
         ors_pkg::ST_WAIT: begin
            if (s_ff.tick == TICK_LAST) begin
               if (s_ff.dly <= 8'h01) begin
                  nxt_s.st = ors_pkg::ST_SEND;
               end else begin
                  nxt_s.dly = s_ff.dly - 8'h01;
               end
            end
         end
         ors_pkg::ST_SEND: begin
            if (fire) begin
               unique case (s_ff.seg)
                  ors_pkg::SG_ITEM: begin
                     if (4'(s_ff.chr) + 4'h1 < s_ff.rbuf.len[s_ff.item]) begin
                        nxt_s.chr = s_ff.chr + 3'h1;
                     end else if (s_ff.item + 2'h1 < s_ff.rbuf.n) begin
                        nxt_s.seg = ors_pkg::SG_COMMA;
                     end else begin
                        nxt_s.seg = ors_pkg::SG_CR;
                     end
                  end
                  ors_pkg::SG_COMMA: begin
                     nxt_s.item = s_ff.item + 2'h1;
                     nxt_s.chr = 3'h0;
                     nxt_s.seg = ors_pkg::SG_ITEM;
                  end
                  ors_pkg::SG_CR: begin
                     if (s_ff.cfg.serial) begin
                        nxt_s.pend = 1'b0;
                        nxt_s.st = ors_pkg::ST_IDLE;
                     end else begin
                        nxt_s.seg = ors_pkg::SG_LF;
                     end
                  end
                  ors_pkg::SG_LF: begin
                     nxt_s.pend = 1'b0;
                     nxt_s.st = ors_pkg::ST_IDLE;
                  end
               endcase
               if (nxt_s.pend && s_ff.cfg.serial && s_ff.cfg.cdly != 8'h00) begin
                  nxt_s.st = ors_pkg::ST_WAIT;
                  nxt_s.dly = s_ff.cfg.cdly;
               end
            end
         end
         default: nxt_s.st = ors_pkg::ST_IDLE;
      endcase

      // a query carries only its response image, no parameters
      if (q_valid) begin
         if (s_ff.cfg.serial && s_ff.pend) begin
            ev = 1'b1;
            code = `ORS_ERR_BUSY;
         end else begin
            // on the bus this overwrites an unread answer
            nxt_s.rbuf = q_resp;
            nxt_s.pend = 1'b1;
            nxt_s.seg = ors_pkg::SG_ITEM;
            nxt_s.item = 2'h0;
            nxt_s.chr = 3'h0;
            nxt_s.st = ors_pkg::ST_SEND;
            if (s_ff.cfg.serial && s_ff.cfg.tdly != 8'h00) begin
               nxt_s.st = ors_pkg::ST_WAIT;
               nxt_s.dly = s_ff.cfg.tdly;
            end
         end
      end

      // error reporting: clear first so a same-cycle error wins
      if (err_clear) begin
         nxt_s.sb_err = 1'b0;
         nxt_s.err_show = 1'b0;
      end
      if (ev) begin
         if (code == `ORS_ERR_BUSY) begin
            nxt_s.err_num = code;
         end else if (code != 4'h0 && code <= `ORS_ERR_MAXM && s_ff.emask[3'(code - 4'h1)]) begin
            nxt_s.err_num = code;
            nxt_s.sb_err = 1'b1;
            nxt_s.err_show = 1'b1;
         end
         // a masked error changes nothing at all
      end

      // service request bit, serial poll clear loses to a new cause
      if (spoll_done) begin
         nxt_s.sb_rqs = 1'b0;
      end
      nxt_s.sb_prev = low6;
      if (low6 != s_ff.sb_prev && (|(low6 & s_ff.smask[5:0]))) begin
         nxt_s.sb_rqs = 1'b1;
      end

      if (init_req) begin
         nxt_s.emask = `ORS_EMASK_DEF;
         nxt_s.smask = `ORS_SMASK_DEF;
         nxt_s.pmask = `ORS_PMASK_DEF;
      end

      nxt_s.txb = byte_of(nxt_s);

      if (!reset_n) begin
         nxt_s = '0;
         nxt_s.emask = `ORS_EMASK_DEF;
         nxt_s.cfg.term = `ORS_CR;
         nxt_s.txb = `ORS_CR;
      end
   end

   always_ff @(posedge clk_sys) begin
      s_ff <= nxt_s;
   end

   sequence s_cr_sent;
      fire && !s_ff.cfg.serial && s_ff.seg == ors_pkg::SG_CR && !q_valid;
   endsequence
   sequence s_item_end;
      fire && s_ff.seg == ors_pkg::SG_ITEM && !q_valid &&
      4'(s_ff.chr) + 4'h1 == s_ff.rbuf.len[s_ff.item] && s_ff.item + 2'h1 < s_ff.rbuf.n;
   endsequence

   property p_eoi_lf;
      @(posedge clk_sys) disable iff (!reset_n)
      tx_eoi |-> tx_data == `ORS_LF && tx_valid && !s_ff.cfg.serial;
   endproperty
   a_eoi_lf: assert property (p_eoi_lf) else $error("eoi without lf");

   property p_crlf;
      @(posedge clk_sys) disable iff (!reset_n)
      s_cr_sent |=> s_ff.pend && s_ff.seg == ors_pkg::SG_LF && tx_data == `ORS_LF;
   endproperty
   a_crlf: assert property (p_crlf) else $error("cr not followed by lf");

   property p_comma;
      @(posedge clk_sys) disable iff (!reset_n)
      s_item_end |=> tx_data == `ORS_COMMA ##1 1'b1;
   endproperty
   a_comma: assert property (p_comma) else $error("missing comma");

   property p_no_talk;
      @(posedge clk_sys) disable iff (!reset_n)
      !s_ff.cfg.serial && !(talk_rd && !s_ff.cfg.lonly) |-> !tx_valid;
   endproperty
   a_no_talk: assert property (p_no_talk) else $error("talked unaddressed");

   property p_replace;
      @(posedge clk_sys) disable iff (!reset_n)
      !s_ff.cfg.serial && q_valid |=> s_ff.pend && s_ff.rbuf == $past(q_resp) && s_ff.item == 2'h0;
   endproperty
   a_replace: assert property (p_replace) else $error("response not replaced");

   property p_busy;
      @(posedge clk_sys) disable iff (!reset_n)
      s_ff.cfg.serial && s_ff.pend && q_valid && !fire |=> err_num == `ORS_ERR_BUSY && $stable(s_ff.rbuf);
   endproperty
   a_busy: assert property (p_busy) else $error("busy query not refused");

   property p_ser_start;
      @(posedge clk_sys) disable iff (!reset_n)
      s_ff.cfg.serial && !s_ff.pend && q_valid && s_ff.cfg.tdly == 8'h00 && s_ff.cfg.cdly == 8'h00 &&
         !m_valid |=> tx_valid [*2];
   endproperty
   a_ser_start: assert property (p_ser_start) else $error("serial send late");

   property p_def_masks;
      @(posedge clk_sys) disable iff (!reset_n)
      (m_valid && m_cmd.cnt == 4'h0) || init_req |=>
         s_ff.emask == `ORS_EMASK_DEF && s_ff.smask == 8'h00 && s_ff.pmask == 8'h00;
   endproperty
   a_def_masks: assert property (p_def_masks) else $error("mask defaults wrong");

   property p_range;
      @(posedge clk_sys) disable iff (!reset_n)
      m_valid && m_cmd.cnt != 4'h0 && m_cmd.par[0] > `ORS_MAXV && !init_req |=> $stable(s_ff.emask);
   endproperty
   a_range: assert property (p_range) else $error("bad mask applied");

   property p_masked_err;
      @(posedge clk_sys) disable iff (!reset_n)
      err_valid && !m_valid && !q_valid && !err_clear && err_in != 4'h0 && err_in <= `ORS_ERR_MAXM &&
         !s_ff.emask[3'(err_in - 4'h1)]
         |=> $stable(err_num) && $stable(s_ff.sb_err) && $stable(err_show);
   endproperty
   a_masked_err: assert property (p_masked_err) else $error("masked error visible");

   property p_srq;
      @(posedge clk_sys) disable iff (!reset_n)
      $rose(s_ff.sb_rqs) |-> |($past(low6) & $past(s_ff.smask[5:0]));
   endproperty
   a_srq: assert property (p_srq) else $error("service request without cause");
endmodule // ors_core

// *** rtl/ors_defines.svh ***
`ifndef ORS_DEFINES_SVH
`define ORS_DEFINES_SVH
`define ORS_A_CTRL 12'h000
`define ORS_A_SCFG 12'h004
`define ORS_A_MASK 12'h008
`define ORS_A_STAT 12'h00C
`define ORS_EMASK_DEF 8'hDF
`define ORS_SMASK_DEF 8'h00
`define ORS_PMASK_DEF 8'h00
`define ORS_CR 8'h0D
`define ORS_LF 8'h0A
`define ORS_COMMA 8'h2C
`define ORS_MAXV 16'h00FF
`define ORS_MAXP 4'h3
`define ORS_ERR_PCNT 4'h2
`define ORS_ERR_PRNG 4'h3
`define ORS_ERR_BUSY 4'hA
`define ORS_ERR_MAXM 4'h8
`define ORS_CLK_NS 4
`define ORS_TICK_NS 1000
`define ORS_TICK_CYC (`ORS_TICK_NS / `ORS_CLK_NS)
`endif

// *** rtl/ors_pkg.sv ***
package ors_pkg;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_SEND = 2'b11} ors_tx_st_t;
   typedef enum logic [1:0] {SG_ITEM = 2'b00, SG_COMMA = 2'b01, SG_CR = 2'b11, SG_LF = 2'b10} ors_seg_t;
   // item k, char j sent first-to-last; len is 1..8
   typedef struct packed {
      logic [1:0]            n;
      logic [2:0][3:0]       len;
      logic [2:0][7:0][7:0]  chr;
   } ors_resp_t;
   typedef struct packed {
      logic [3:0]       cnt;
      logic [2:0][15:0] par;
   } ors_mask_cmd_t;
   typedef struct packed {
      logic       serial;
      logic       lonly;
      logic [7:0] term;
      logic [7:0] tdly;
      logic [7:0] cdly;
   } ors_cfg_t;
   typedef struct packed {
      ors_cfg_t   cfg;
      logic [7:0] emask;
      logic [7:0] smask;
      logic [7:0] pmask;
      logic       sb_err;
      logic       sb_rqs;
      logic [5:0] sb_prev;
      logic [3:0] err_num;
      logic       err_show;
      ors_resp_t  rbuf;
      logic       pend;
      ors_tx_st_t st;
      ors_seg_t   seg;
      logic [1:0] item;
      logic [2:0] chr;
      logic [7:0] txb;
      logic [7:0] dly;
      logic [7:0] tick;
      logic [31:0] prdata;
      logic       pslverr;
   } ors_state_t;
endpackage

// *** test/ors_host_model.sv ***
module ors_host_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   // response stream from the device
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_eoi,
   // pacing chosen by the bench
   input  wire logic       slow,
   output      logic       tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [8:0] got[$];
   logic       ph_ff;

   // a slow host takes a byte only every other cycle, so bytes must wait
   assign tx_ready = !slow || ph_ff;

   always @(posedge clk_sys) begin
      ph_ff <= reset_n ? !ph_ff : 1'b0;
      if (reset_n && tx_valid && tx_ready) begin
         got.push_back({tx_eoi, tx_data});
      end
   end
endmodule // ors_host_model

// *** test/testbench.sv ***
`include "ors_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic                   q_valid, m_valid, err_valid, err_clear, init_req, spoll_done, talk_rd;
   logic                   srq, ppoll_resp, tx_valid, tx_ready, tx_eoi, err_show, slow;
   logic [3:0]             err_in, err_num;
   logic [4:0]             stat_in;
   logic [7:0]             tx_data;
   ors_pkg::ors_resp_t     q_resp;
   ors_pkg::ors_mask_cmd_t m_cmd;
   int                     num_errors, total_checks, rd_idx;

   localparam logic [7:0]  EMASK_DEF = `ORS_EMASK_DEF;

   always #2 clk_sys = ~clk_sys;

   ors_core uut (.clk_sys, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .q_valid, .q_resp, .m_valid, .m_cmd, .err_valid, .err_in, .err_clear, .init_req, .stat_in, .talk_rd,
      .spoll_done, .srq, .ppoll_resp, .tx_valid, .tx_ready, .tx_data, .tx_eoi, .err_show, .err_num);

   ors_host_model host (.clk_sys, .reset_n, .tx_valid, .tx_data, .tx_eoi, .slow, .tx_ready);

   task give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task timed_out;
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      give_verdict;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) timed_out();
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // only the bare instruction goes in, never with listen-only set
   task query(input string a, input string b, input string c);
      string              s[3];
      ors_pkg::ors_resp_t r;
      s = '{a, b, c};
      r   = '0;
      r.n = (c != "") ? 2'h3 : (b != "") ? 2'h2 : 2'h1;
      for (int k = 0; k < 3; k++) begin
         r.len[k] = 4'(s[k].len());
         for (int j = 0; j < s[k].len(); j++) r.chr[k][j] = s[k][j];
      end
      @(posedge clk_sys);
      q_resp  <= r;
      q_valid <= 1'b1;
      @(posedge clk_sys);
      q_valid <= 1'b0;
   endtask

   task mask(input logic [3:0] c, input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
      @(posedge clk_sys);
      m_cmd   <= {c, d, b, a};
      m_valid <= 1'b1;
      @(posedge clk_sys);
      m_valid <= 1'b0;
   endtask

   task err(input logic [3:0] n);
      @(posedge clk_sys);
      err_in    <= n;
      err_valid <= 1'b1;
      @(posedge clk_sys);
      err_valid <= 1'b0;
   endtask

   task clear_err;
      @(posedge clk_sys);
      err_clear <= 1'b1;
      @(posedge clk_sys);
      err_clear <= 1'b0;
   endtask

   // eoi is expected on the closing byte only when on the bus
   task expect_resp(input string x, input logic bus);
      int n;
      n = 0;
      while (host.got.size() < rd_idx + x.len() && n < 1000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 1000) timed_out();
      repeat (6) @(negedge clk_sys);
      chk(host.got.size(), rd_idx + x.len(), "byte count");
      for (int i = 0; i < x.len(); i++) begin
         chk({23'h0, host.got[rd_idx + i]}, {23'h0, bus && i == x.len() - 1, 8'(x[i])}, "byte");
      end
      rd_idx = host.got.size();
      @(posedge clk_sys);
   endtask

   initial begin
      clk_sys = 1'b0;
      {reset_n, psel, penable, pwrite, paddr, pwdata, q_valid, m_valid} = '0;
      {err_valid, err_in, err_clear, init_req, stat_in, talk_rd, spoll_done, slow} = '0;
      q_resp = '0;
      m_cmd  = '0;
      {num_errors, total_checks, rd_idx} = '0;
      tick(2);
      reset_n <= 1'b1;
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0000_00DF, "mask reset");
      apb(1'b0, `ORS_A_SCFG, 32'h0);
      chk({24'h0, rd[7:0]}, 32'h0000_000D, "terminator reset");
      apb(1'b0, 12'h0F0, 32'h0);
      chk({31'h0, e}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      // bus mode
      talk_rd <= 1'b1;
      query("12", "-3", "1");
      expect_resp("12,-3,1\015\n", 1'b1);
      talk_rd <= 1'b0;
      query("5", "", "");
      query("66", "7", "");
      tick(5);
      @(negedge clk_sys);
      chk({31'h0, tx_valid}, 32'h0, "sent untalked");
      @(posedge clk_sys);
      talk_rd <= 1'b1;
      expect_resp("66,7\015\n", 1'b1);
      mask(4'h3, 16'h07, 16'h07, 16'h09);
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0009_0707, "mask three");
      chk(host.got.size(), rd_idx, "mask output");
      mask(4'h1, 16'h0100, 16'h0, 16'h0);
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0009_0707, "range ignored");
      chk({28'h0, err_num}, 32'h3, "range error");
      clear_err();
      mask(4'h4, 16'hFF, 16'h10, 16'h01);
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0001_10FF, "first three");
      chk({28'h0, err_num}, 32'h2, "count error");
      clear_err();
      // a masked status change must not request service
      stat_in <= 5'h01;
      tick(3);
      @(negedge clk_sys);
      chk({30'h0, srq, ppoll_resp}, 32'h1, "ppoll only");
      @(posedge clk_sys);
      stat_in <= 5'h11;
      tick(3);
      @(negedge clk_sys);
      chk({31'h0, srq}, 32'h1, "srq set");
      @(posedge clk_sys);
      spoll_done <= 1'b1;
      @(posedge clk_sys);
      spoll_done <= 1'b0;
      tick(2);
      chk({31'h0, srq}, 32'h0, "srq cleared");
      mask(4'h0, 16'h0, 16'h0, 16'h0);
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0000_00DF, "empty mask");
      for (int n = 1; n <= 8; n++) begin
         err(4'(n));
         @(negedge clk_sys);
         chk({31'h0, err_show}, {31'h0, EMASK_DEF[n - 1]}, "shown");
         if (EMASK_DEF[n - 1]) chk({28'h0, err_num}, 32'(n), "number");
         apb(1'b0, `ORS_A_STAT, 32'h0);
         chk({31'h0, rd[5]}, {31'h0, EMASK_DEF[n - 1]}, "status bit");
         clear_err();
      end
      mask(4'h3, 16'h01, 16'h02, 16'h03);
      @(posedge clk_sys);
      init_req <= 1'b1;
      @(posedge clk_sys);
      init_req <= 1'b0;
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0000_00DF, "init masks");
      // serial mode, host pacing slowly so the response stays in progress
      apb(1'b1, `ORS_A_CTRL, 32'h1);
      slow    <= 1'b1;
      talk_rd <= 1'b0;
      mask(4'h3, 16'hDF, 16'h44, 16'h22);
      apb(1'b0, `ORS_A_MASK, 32'h0);
      chk(rd, 32'h0000_00DF, "serial masks");
      query("12345678", "", "");
      tick(2);
      query("9", "", "");
      @(negedge clk_sys);
      chk({28'h0, err_num}, 32'hA, "busy error");
      expect_resp("12345678\015", 1'b0);
      apb(1'b1, `ORS_A_SCFG, 32'h3B);
      query("x", "", "");
      expect_resp("x;", 1'b0);
      // one us turnaround and intercharacter delay
      apb(1'b1, `ORS_A_SCFG, 32'h0001_013B);
      query("yz", "", "");
      @(negedge clk_sys);
      chk({31'h0, tx_valid}, 32'h0, "turnaround wait");
      expect_resp("yz;", 1'b0);
      give_verdict();
   end
endmodule // testbench
